// File: etc_act_if.sv
// Activation handshake and slot configuration between selector and engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface etc_act_if;
   logic gen_en;
   logic [etc_pkg::NUM_SLOTS-1:0] slot_en;
   logic [etc_pkg::NUM_SLOTS-1:0][etc_pkg::SLOT_W-1:0] slot_src;
   logic req;
   logic [etc_pkg::SLOT_W-1:0] vector;
   logic ack;
   logic [etc_pkg::SLOT_W-1:0] ack_vector;
   modport engine (output gen_en, slot_en, slot_src, ack, ack_vector, input req, vector);
   modport selector (input gen_en, slot_en, slot_src, ack, ack_vector, output req, vector);
endinterface

// File: etc_mem_model.sv
// Word-wide memory slave standing for SRAM and peripheral registers.
// Assumes word transfers only; slow adds two wait cycles per request.
`timescale 1ns/1ps
module etc_mem_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Memory slave
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] mem_size,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   // Pacing
   input wire logic slow
);
   logic [31:0] mem [0:2047];
   logic [2:0] wait_ff;
   logic [31:0] last_ff;
   assign mem_ack = mem_req && (wait_ff >= (slow ? 3'h2 : 3'h0));
   // Inverted stale data so a late sample never looks right
   assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr[12:2]] : ~last_ff;
   // Plain always: the bench also preloads the array directly
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_ff <= 3'h0;
         last_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= (mem_req && !mem_ack) ? wait_ff + 3'h1 : 3'h0;
         if (mem_ack && !mem_we)
            last_ff <= mem[mem_addr[12:2]];
         if (mem_ack && mem_we)
            mem[mem_addr[12:2]] <= mem_wdata;
      end
   end
endmodule // etc_mem_model

// File: etc_pkg.sv
// Constants shared by the event triggered transfer controller files.
// Assumes a 32-bit APB register bus and a 32-bit byte-addressed memory port.
package etc_pkg;
   localparam int NUM_SLOTS = 32;
   localparam int SLOT_W = 5;
   localparam int CNT_W = 16;
   localparam int APB_AW = 8;
   // APB register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BASE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_SLOT0 = 8'h80;
   // Register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int SLOT_SRC_LSB = 0;
   localparam int SLOT_EN_BIT = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_VEC_LSB = 8;
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   // Descriptor layout, four words per descriptor
   localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
   localparam logic [31:0] DESC_SRC_OFF = 32'h0000_0004;
   localparam logic [31:0] DESC_DST_OFF = 32'h0000_0008;
   localparam logic [31:0] DESC_CNT_OFF = 32'h0000_000C;
   localparam int DESC_VEC_SHIFT = 4;
   // Mode word and count word fields
   localparam int MD_MODE_LSB = 0;
   localparam int MD_SIZE_LSB = 2;
   localparam int MD_SRC_INC = 4;
   localparam int MD_DST_INC = 5;
   localparam int MD_RPT_DST = 6;
   localparam int MD_CHAIN = 7;
   localparam int CNT_LSB = 0;
   localparam int RELOAD_LSB = 16;
   // Transfer mode and size encodings
   localparam logic [1:0] XM_NORMAL = 2'h0;
   localparam logic [1:0] XM_REPEAT = 2'h1;
   localparam logic [1:0] XM_BLOCK = 2'h2;
   localparam logic [1:0] SZ_WORD = 2'h2;
endpackage

// File: etc_sel.sv
// Per-vector request selector: routes peripheral requests to the engine or the CPU.
// Assumes request lines come from logic on pclk.
`timescale 1ns/1ps
module etc_sel #(
   parameter int NUM_SRC = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Peripheral request lines
   input wire logic [NUM_SRC-1:0] src_req,
   // Interrupts passed to the CPU
   output logic [etc_pkg::NUM_SLOTS-1:0] cpu_irq,
   // Engine side
   etc_act_if.selector act
);
   initial begin
      if (NUM_SRC < 1 || NUM_SRC > (1 << etc_pkg::SLOT_W)) $error("etc_sel: NUM_SRC out of range");
   end

   logic [etc_pkg::NUM_SLOTS-1:0] sel_lvl;
   logic [etc_pkg::NUM_SLOTS-1:0] prev_ff, nxt_prev;
   logic [etc_pkg::NUM_SLOTS-1:0] pend_ff, nxt_pend;
   logic [etc_pkg::NUM_SLOTS-1:0] irq_ff, nxt_irq;

   genvar g;
   generate
      for (g = 0; g < etc_pkg::NUM_SLOTS; g++) begin : g_slot
         // Out-of-range source numbers select nothing
         assign sel_lvl[g] = (int'(act.slot_src[g]) < NUM_SRC) ? src_req[act.slot_src[g]] : 1'b0; // R6
      end
   endgenerate

   always_comb begin
      logic [etc_pkg::NUM_SLOTS-1:0] clr;
      clr = '0;
      if (act.ack) begin
         clr[act.ack_vector] = 1'b1;
      end
      nxt_prev = sel_lvl;
      // Set wins over clear so a request landing on the ack cycle stays pending
      nxt_pend = (pend_ff & ~clr) | (sel_lvl & ~prev_ff & act.slot_en); // R4
      nxt_irq = sel_lvl & ~act.slot_en; // R4
   end

   always_comb begin
      act.req = 1'b0;
      act.vector = '0;
      for (int n = etc_pkg::NUM_SLOTS - 1; n >= 0; n--) begin
         if (pend_ff[n] && act.gen_en) begin
            act.req = 1'b1;
            act.vector = n[etc_pkg::SLOT_W-1:0]; // R5
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= '0;
         pend_ff <= '0;
         irq_ff <= '0;
      end else begin
         prev_ff <= nxt_prev;
         pend_ff <= nxt_pend;
         irq_ff <= nxt_irq;
      end
   end

   assign cpu_irq = irq_ff;
endmodule // etc_sel

// File: etc_top.sv
// Event triggered transfer controller: APB registers, descriptor fetch and data mover.
// Assumes a memory slave that answers each held request with a one-cycle mem_ack.
`timescale 1ns/1ps
// What this block does
// R1 - Normal mode: one unit per activation
// R2 - Repeat mode: reload address after count units
// R3 - Block mode: one whole block per activation
// R4 - Slot enable picks engine, else CPU interrupt
// R5 - Slot number is vector, locates descriptor
// R6 - Five-bit field picks request source per slot
// R7 - Chain bit runs next descriptor, same activation
// R8 - Software places descriptors in memory beforehand
// R9 - Per-address fixed or increment, repeat side select
module etc_top #(
   parameter int NUM_SRC = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [etc_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral requests and CPU interrupts
   input wire logic [NUM_SRC-1:0] src_req,
   output logic [etc_pkg::NUM_SLOTS-1:0] cpu_irq,
   // Memory master
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [1:0] mem_size,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // Status
   output logic busy
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_MODE, ST_SRC, ST_DST, ST_CNT, ST_RD, ST_WR, ST_WB_SRC, ST_WB_DST, ST_WB_CNT
   } etc_state_type;

   etc_act_if act ();

   etc_sel #(.NUM_SRC(NUM_SRC)) u_sel (
      .pclk(pclk),
      .presetn(presetn),
      .src_req(src_req),
      .cpu_irq(cpu_irq),
      .act(act)
   );

   function automatic logic slot_hit(input logic [etc_pkg::APB_AW-1:0] a);
      slot_hit = (a >= etc_pkg::REG_SLOT0) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [etc_pkg::SLOT_W-1:0] slot_idx(input logic [etc_pkg::APB_AW-1:0] a);
      logic [etc_pkg::APB_AW-1:0] d;
      d = a - etc_pkg::REG_SLOT0;
      slot_idx = d[etc_pkg::SLOT_W+1:2];
   endfunction

   // Register file
   logic ctrl_en_ff, nxt_ctrl_en;
   logic [31:0] base_ff, nxt_base;
   logic [etc_pkg::NUM_SLOTS-1:0] slot_en_ff, nxt_slot_en;
   logic [etc_pkg::NUM_SLOTS-1:0][etc_pkg::SLOT_W-1:0] slot_src_ff, nxt_slot_src;
   logic [31:0] prdata_ff, nxt_prdata;
   logic perr_ff, nxt_perr;
   logic setup;
   logic wr_acc;
   logic [etc_pkg::SLOT_W-1:0] vec_ff;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;

   always_comb begin
      logic hit;
      hit = (paddr == etc_pkg::REG_CTRL) || (paddr == etc_pkg::REG_BASE) ||
            (paddr == etc_pkg::REG_STATUS) || slot_hit(paddr);
      nxt_ctrl_en = ctrl_en_ff;
      nxt_base = base_ff;
      nxt_slot_en = slot_en_ff;
      nxt_slot_src = slot_src_ff;
      nxt_prdata = prdata_ff;
      nxt_perr = perr_ff;
      if (setup) begin
         nxt_perr = !hit;
         nxt_prdata = 32'h0000_0000;
         if (paddr == etc_pkg::REG_CTRL) begin
            nxt_prdata[etc_pkg::CTRL_EN_BIT] = ctrl_en_ff;
         end else if (paddr == etc_pkg::REG_BASE) begin
            nxt_prdata = base_ff;
         end else if (paddr == etc_pkg::REG_STATUS) begin
            nxt_prdata[etc_pkg::STAT_BUSY_BIT] = busy;
            nxt_prdata[etc_pkg::STAT_VEC_LSB +: etc_pkg::SLOT_W] = vec_ff;
         end else if (slot_hit(paddr)) begin
            nxt_prdata[etc_pkg::SLOT_SRC_LSB +: etc_pkg::SLOT_W] = slot_src_ff[slot_idx(paddr)];
            nxt_prdata[etc_pkg::SLOT_EN_BIT] = slot_en_ff[slot_idx(paddr)];
         end
      end
      if (wr_acc && !perr_ff) begin
         if (paddr == etc_pkg::REG_CTRL) begin
            nxt_ctrl_en = pwdata[etc_pkg::CTRL_EN_BIT];
         end else if (paddr == etc_pkg::REG_BASE) begin
            // Descriptors stay word aligned
            nxt_base = {pwdata[31:2], 2'h0};
         end else if (slot_hit(paddr)) begin
            nxt_slot_src[slot_idx(paddr)] = pwdata[etc_pkg::SLOT_SRC_LSB +: etc_pkg::SLOT_W]; // R6
            nxt_slot_en[slot_idx(paddr)] = pwdata[etc_pkg::SLOT_EN_BIT]; // R4
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_ff <= 1'b0;
         base_ff <= etc_pkg::BASE_RST;
         slot_en_ff <= '0;
         slot_src_ff <= '0;
         prdata_ff <= 32'h0000_0000;
         perr_ff <= 1'b0;
      end else begin
         ctrl_en_ff <= nxt_ctrl_en;
         base_ff <= nxt_base;
         slot_en_ff <= nxt_slot_en;
         slot_src_ff <= nxt_slot_src;
         prdata_ff <= nxt_prdata;
         perr_ff <= nxt_perr;
      end
   end

   assign pready = penable;
   assign pslverr = psel && penable && perr_ff;
   assign prdata = prdata_ff;
   assign act.gen_en = ctrl_en_ff;
   assign act.slot_en = slot_en_ff;
   assign act.slot_src = slot_src_ff;

   // Transfer engine
   etc_state_type state_ff, nxt_state;
   logic [etc_pkg::SLOT_W-1:0] nxt_vec;
   logic [31:0] desc_ff, nxt_desc;
   logic [31:0] mode_ff, nxt_mode;
   logic [31:0] src_ff, nxt_src;
   logic [31:0] dst_ff, nxt_dst;
   logic [etc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [etc_pkg::CNT_W-1:0] rel_ff, nxt_rel;
   logic [etc_pkg::CNT_W-1:0] blk_ff, nxt_blk;
   logic [31:0] buf_ff, nxt_buf;
   logic req_ff, nxt_req;
   logic we_ff, nxt_we;
   logic [31:0] addr_ff, nxt_addr;
   logic [1:0] size_ff, nxt_size;
   logic [31:0] wdata_ff, nxt_wdata;
   logic done;
   logic [1:0] xmode;
   logic [1:0] usize;
   logic [31:0] unit;
   logic [31:0] rewind;

   assign done = req_ff && mem_ack;
   assign xmode = mode_ff[etc_pkg::MD_MODE_LSB +: 2];
   // Reserved size code falls back to word
   assign usize = (mode_ff[etc_pkg::MD_SIZE_LSB +: 2] > etc_pkg::SZ_WORD) ? etc_pkg::SZ_WORD :
                  mode_ff[etc_pkg::MD_SIZE_LSB +: 2];
   assign unit = 32'h0000_0001 << usize;
   // Size zero stands for 65536 units, so the rewind needs bit 16
   assign rewind = {15'h0000, (rel_ff == 16'h0000), rel_ff} << usize;
   assign act.ack = (state_ff == ST_WB_CNT) && done && !mode_ff[etc_pkg::MD_CHAIN];
   assign act.ack_vector = vec_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_vec = vec_ff;
      nxt_desc = desc_ff;
      nxt_mode = mode_ff;
      nxt_src = src_ff;
      nxt_dst = dst_ff;
      nxt_cnt = cnt_ff;
      nxt_rel = rel_ff;
      nxt_blk = blk_ff;
      nxt_buf = buf_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (act.req) begin
               nxt_vec = act.vector;
               nxt_desc = base_ff + ({27'h000_0000, act.vector} << etc_pkg::DESC_VEC_SHIFT); // R5
               nxt_state = ST_MODE;
            end
         end
         ST_MODE: begin
            if (done) begin
               nxt_mode = mem_rdata; // R8
               nxt_state = ST_SRC;
            end
         end
         ST_SRC: begin
            if (done) begin
               nxt_src = mem_rdata;
               nxt_state = ST_DST;
            end
         end
         ST_DST: begin
            if (done) begin
               nxt_dst = mem_rdata;
               nxt_state = ST_CNT;
            end
         end
         ST_CNT: begin
            if (done) begin
               nxt_cnt = mem_rdata[etc_pkg::CNT_LSB +: etc_pkg::CNT_W];
               nxt_rel = mem_rdata[etc_pkg::RELOAD_LSB +: etc_pkg::CNT_W];
               // Block size zero wraps and moves the full 65536 units
               nxt_blk = (xmode == etc_pkg::XM_BLOCK) ? mem_rdata[etc_pkg::RELOAD_LSB +: etc_pkg::CNT_W] :
                         16'h0001; // R1 R3
               nxt_state = ST_RD;
            end
         end
         ST_RD: begin
            if (done) begin
               nxt_buf = mem_rdata;
               nxt_state = ST_WR;
            end
         end
         ST_WR: begin
            if (done) begin
               if (mode_ff[etc_pkg::MD_SRC_INC]) begin
                  nxt_src = src_ff + unit; // R9
               end
               if (mode_ff[etc_pkg::MD_DST_INC]) begin
                  nxt_dst = dst_ff + unit; // R9
               end
               if (blk_ff != 16'h0001) begin
                  nxt_blk = blk_ff - 16'h0001; // R3
                  nxt_state = ST_RD;
               end else begin
                  nxt_cnt = cnt_ff - 16'h0001; // R1
                  if ((xmode == etc_pkg::XM_REPEAT && cnt_ff == 16'h0001) || xmode == etc_pkg::XM_BLOCK) begin
                     if (xmode == etc_pkg::XM_REPEAT) begin
                        nxt_cnt = rel_ff; // R2
                     end
                     // Only an incrementing address has moved and needs the rewind
                     if (mode_ff[etc_pkg::MD_RPT_DST] && mode_ff[etc_pkg::MD_DST_INC]) begin
                        nxt_dst = dst_ff + unit - rewind; // R2 R9
                     end else if (!mode_ff[etc_pkg::MD_RPT_DST] && mode_ff[etc_pkg::MD_SRC_INC]) begin
                        nxt_src = src_ff + unit - rewind; // R2 R9
                     end
                  end
                  nxt_state = ST_WB_SRC;
               end
            end
         end
         ST_WB_SRC: begin
            if (done) begin
               nxt_state = ST_WB_DST;
            end
         end
         ST_WB_DST: begin
            if (done) begin
               nxt_state = ST_WB_CNT;
            end
         end
         ST_WB_CNT: begin
            if (done) begin
               if (mode_ff[etc_pkg::MD_CHAIN]) begin
                  nxt_desc = desc_ff + etc_pkg::DESC_BYTES; // R7
                  nxt_state = ST_MODE; // R7
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
      endcase
   end

   // Memory request follows the state being entered
   always_comb begin
      nxt_req = 1'b1;
      nxt_we = 1'b0;
      nxt_size = etc_pkg::SZ_WORD;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      unique case (nxt_state)
         ST_IDLE: nxt_req = 1'b0;
         ST_MODE: nxt_addr = nxt_desc;
         ST_SRC: nxt_addr = nxt_desc + etc_pkg::DESC_SRC_OFF;
         ST_DST: nxt_addr = nxt_desc + etc_pkg::DESC_DST_OFF;
         ST_CNT: nxt_addr = nxt_desc + etc_pkg::DESC_CNT_OFF;
         ST_RD: begin
            nxt_addr = nxt_src;
            nxt_size = usize;
         end
         ST_WR: begin
            nxt_addr = nxt_dst;
            nxt_size = usize;
            nxt_we = 1'b1;
            nxt_wdata = nxt_buf;
         end
         ST_WB_SRC: begin
            nxt_addr = desc_ff + etc_pkg::DESC_SRC_OFF;
            nxt_we = 1'b1;
            nxt_wdata = nxt_src;
         end
         ST_WB_DST: begin
            nxt_addr = desc_ff + etc_pkg::DESC_DST_OFF;
            nxt_we = 1'b1;
            nxt_wdata = nxt_dst;
         end
         ST_WB_CNT: begin
            nxt_addr = desc_ff + etc_pkg::DESC_CNT_OFF;
            nxt_we = 1'b1;
            nxt_wdata = {nxt_rel, nxt_cnt};
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         vec_ff <= '0;
         desc_ff <= 32'h0000_0000;
         mode_ff <= 32'h0000_0000;
         src_ff <= 32'h0000_0000;
         dst_ff <= 32'h0000_0000;
         cnt_ff <= 16'h0000;
         rel_ff <= 16'h0000;
         blk_ff <= 16'h0001;
         buf_ff <= 32'h0000_0000;
         req_ff <= 1'b0;
         we_ff <= 1'b0;
         addr_ff <= 32'h0000_0000;
         size_ff <= 2'h0;
         wdata_ff <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         vec_ff <= nxt_vec;
         desc_ff <= nxt_desc;
         mode_ff <= nxt_mode;
         src_ff <= nxt_src;
         dst_ff <= nxt_dst;
         cnt_ff <= nxt_cnt;
         rel_ff <= nxt_rel;
         blk_ff <= nxt_blk;
         buf_ff <= nxt_buf;
         req_ff <= nxt_req;
         we_ff <= nxt_we;
         addr_ff <= nxt_addr;
         size_ff <= nxt_size;
         wdata_ff <= nxt_wdata;
      end
   end

   assign mem_req = req_ff;
   assign mem_we = we_ff;
   assign mem_addr = addr_ff;
   assign mem_size = size_ff;
   assign mem_wdata = wdata_ff;
   assign busy = (state_ff != ST_IDLE);
endmodule // etc_top

// File: etc_top_checker.sv
// Concurrent checks on the transfer controller's memory and interrupt ports.
// Assumes descriptor tables below 0x1000 and data areas above it.
`timescale 1ns/1ps
module etc_top_checker #(
   parameter int NUM_SRC = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Requests and interrupts
   input wire logic [NUM_SRC-1:0] src_req,
   input wire logic [etc_pkg::NUM_SLOTS-1:0] cpu_irq,
   // Memory master
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] mem_size,
   input wire logic mem_ack,
   input wire logic busy
);
   localparam logic [31:0] TABLE_TOP = 32'h0000_1000;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_irq_cause;
      cpu_irq != '0 |-> $past(src_req) != '0;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("cpu irq without source");
   property p_mem_only_busy;
      mem_req |-> busy;
   endproperty
   a_mem_only_busy: assert property (p_mem_only_busy) else $error("memory access while idle");
   property p_desc_first;
      $rose(busy) |-> mem_req && !mem_we && mem_addr[3:0] == 4'h0 && mem_addr < TABLE_TOP;
   endproperty
   a_desc_first: assert property (p_desc_first) else $error("activation not started by mode read");
   property p_desc_next;
      mem_req && mem_ack && !mem_we && mem_addr < TABLE_TOP && mem_addr[3:0] != 4'hC
         |=> mem_req && !mem_we && mem_addr == $past(mem_addr) + 32'h0000_0004;
   endproperty
   a_desc_next: assert property (p_desc_next) else $error("descriptor words out of order");
   property p_desc_word;
      mem_req && mem_addr < TABLE_TOP |-> mem_size == 2'h2;
   endproperty
   a_desc_word: assert property (p_desc_word) else $error("descriptor access not word sized");
   property p_req_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("memory request changed before ack");
   property p_done_after_cnt;
      $fell(busy) |-> $past(mem_req && mem_ack && mem_we && mem_addr[3:0] == 4'hC);
   endproperty
   a_done_after_cnt: assert property (p_done_after_cnt) else $error("idle without count writeback");
   property p_chain_next;
      (mem_req && mem_ack && mem_we && mem_addr < TABLE_TOP && mem_addr[3:0] == 4'hC) ##1 busy
         |-> mem_req && !mem_we && mem_addr == $past(mem_addr) + 32'h0000_0004;
   endproperty
   a_chain_next: assert property (p_chain_next) else $error("chain did not fetch next descriptor");
   property p_wb_order;
      mem_req && mem_ack && mem_we && mem_addr < TABLE_TOP && mem_addr[3:0] != 4'hC
         |=> mem_req && mem_we && mem_addr == $past(mem_addr) + 32'h0000_0004;
   endproperty
   a_wb_order: assert property (p_wb_order) else $error("address writeback out of order");
endmodule // etc_top_checker

bind etc_top etc_top_checker #(.NUM_SRC(NUM_SRC)) etc_top_checker_i (.pclk(pclk), .presetn(presetn),
   .src_req(src_req), .cpu_irq(cpu_irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_size(mem_size), .mem_ack(mem_ack), .busy(busy));

// File: tb_top.sv
// Self-checking bench for the transfer controller: APB setup, requests, memory results.
// Assumes descriptors are preloaded into the memory model before each request.
`timescale 1ns/1ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, busy, slow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, q;
   logic [31:0] src_req, cpu_irq;
   logic [1:0] mem_size;
   logic e;
   int errors = 0;
   int comparisons = 0;
   etc_top etc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
      .cpu_irq(cpu_irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));
   etc_mem_model etc_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .slow(slow));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a slave that never answers
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic put(input logic [31:0] a, input logic [31:0] v);
      etc_mem_model_i.mem[a[12:2]] = v;
   endtask
   task automatic chk_mem(input logic [31:0] a, input logic [31:0] exp);
      chk(etc_mem_model_i.mem[a[12:2]], exp);
   endtask
   // Pulse one source line; returns the interrupt lines seen one cycle later
   task automatic fire(input int n, output logic [31:0] irq);
      @(posedge pclk);
      src_req[n] <= 1'b1;
      @(posedge pclk);
      src_req[n] <= 1'b0;
      #1 irq = cpu_irq;
   endtask
   task automatic wait_done;
      int n;
      logic rose;
      n = 0;
      rose = 1'b0;
      while (busy !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      rose = (busy === 1'b1);
      while (busy !== 1'b0 && n < 600) begin
         @(posedge pclk);
         n++;
      end
      #1 chk(32'(rose), 32'h0000_0001);
      chk(32'(busy), 32'h0000_0000);
   endtask
   task automatic test_regs;
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      apb(1'b0, 8'h8C, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
      apb(1'b1, 8'h04, 32'h0000_0103);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(q, 32'h0000_0100);
      apb(1'b1, 8'h00, 32'h0000_0001);
      $display("test regs done");
   endtask
   task automatic test_normal;
      logic [31:0] irq;
      apb(1'b1, 8'h8C, 32'h0000_0007);
      fire(7, irq);
      chk(32'(irq[3]), 32'h0000_0001);
      chk(32'(busy), 32'h0000_0000);
      apb(1'b1, 8'h8C, 32'h0000_0107);
      // Descriptors in memory before the request
      put(32'h0000_0130, 32'h0000_0038);
      put(32'h0000_0134, 32'h0000_1000);
      put(32'h0000_0138, 32'h0000_1100);
      put(32'h0000_013C, 32'h0000_0005);
      put(32'h0000_1000, 32'hA5A5_0001);
      put(32'h0000_1004, 32'hA5A5_0002);
      put(32'h0000_1100, 32'h0000_0000);
      put(32'h0000_1104, 32'h0000_0000);
      fire(7, irq);
      chk(32'(irq[3]), 32'h0000_0000);
      wait_done;
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk(q, 32'h0000_0300);
      chk_mem(32'h0000_1100, 32'hA5A5_0001);
      chk_mem(32'h0000_1104, 32'h0000_0000);
      chk_mem(32'h0000_0134, 32'h0000_1004);
      chk_mem(32'h0000_0138, 32'h0000_1104);
      chk_mem(32'h0000_013C, 32'h0000_0004);
      $display("test normal done");
   endtask
   task automatic test_repeat;
      logic [31:0] irq;
      apb(1'b1, 8'h94, 32'h0000_0105);
      put(32'h0000_0150, 32'h0000_0069);
      put(32'h0000_0154, 32'h0000_1200);
      put(32'h0000_0158, 32'h0000_1210);
      put(32'h0000_015C, 32'h0002_0002);
      put(32'h0000_1200, 32'h1111_2222);
      fire(5, irq);
      wait_done;
      chk_mem(32'h0000_1210, 32'h1111_2222);
      chk_mem(32'h0000_0158, 32'h0000_1214);
      chk_mem(32'h0000_015C, 32'h0002_0001);
      put(32'h0000_1200, 32'h3333_4444);
      fire(5, irq);
      wait_done;
      chk_mem(32'h0000_1214, 32'h3333_4444);
      chk_mem(32'h0000_0158, 32'h0000_1210);
      chk_mem(32'h0000_015C, 32'h0002_0002);
      chk_mem(32'h0000_0154, 32'h0000_1200);
      $display("test repeat done");
   endtask
   task automatic test_block_chain;
      logic [31:0] irq;
      slow <= 1'b1;
      apb(1'b1, 8'hA4, 32'h0000_0109);
      put(32'h0000_0190, 32'h0000_00FA);
      put(32'h0000_0194, 32'h0000_1400);
      put(32'h0000_0198, 32'h0000_1500);
      put(32'h0000_019C, 32'h0003_0001);
      put(32'h0000_01A0, 32'h0000_0008);
      put(32'h0000_01A4, 32'h0000_1300);
      put(32'h0000_01A8, 32'h0000_1310);
      put(32'h0000_01AC, 32'h0000_0001);
      put(32'h0000_1300, 32'hC0DE_0001);
      for (int i = 0; i < 3; i++)
         put(32'h0000_1400 + 32'(4 * i), 32'h0000_00B0 + 32'(i));
      fire(9, irq);
      wait_done;
      for (int i = 0; i < 3; i++)
         chk_mem(32'h0000_1500 + 32'(4 * i), 32'h0000_00B0 + 32'(i));
      chk_mem(32'h0000_0194, 32'h0000_140C);
      chk_mem(32'h0000_0198, 32'h0000_1500);
      chk_mem(32'h0000_019C, 32'h0003_0000);
      chk_mem(32'h0000_1310, 32'hC0DE_0001);
      chk_mem(32'h0000_01AC, 32'h0000_0000);
      slow <= 1'b0;
      $display("test block chain done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, slow} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      src_req = 32'h0000_0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      test_regs;
      test_normal;
      test_repeat;
      test_block_chain;
      tally_and_finish;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      tally_and_finish;
   end
endmodule // tb_top
